//--- npic_pkg.sv
// Purpose: constants for the nested priority interrupt controller
// Assumes: one 100 MHz clock, registers reached over a plain strobe port
// Notes: vector index 0 is the top-level pin, 13 the lowest
// Functional notes
// RULE1: request only when flag and enable set
// RULE2: peripheral clear sequence drops the pending latch
// RULE3: any request wakes from wait mode
// RULE4: halt exit picks among wake-capable sources only
// RULE5: non-waking top request follows first serviced
// RULE6: concurrent mode blocks preemption, nested allows it; code still lets the pin interrupt preempt in concurrent mode
// RULE7: fixed order, lower vector number wins ties
// RULE8: level bits encode 10,01,00,11 for levels 0-3
// RULE9: entry loads the vector's priority pair
// RULE10: trap and reset still taken at level 3
// RULE11: priority registers reset ff, top nibble reads ones
// RULE12: one pair per vector, descending address order
// RULE13: writing level-0 pattern keeps that pair
// RULE14: pin, reset, trap service give level 3
// RULE15: pin interrupt pair stored but ignored
// RULE16: raised own pair re-enters while still pending
// RULE17: enable/halt/wait load 10, disable/trap 11, return restores
// RULE18: changed level holds until next return or change
// RULE19: fixed vector addresses from fffe down to ffe0
// RULE20: only pin, clock and external groups wake halt
// RULE21: serial-peripheral and reload-timer wake conditionally
// RULE22: no stack overflow detection or signal
// RULE23: serviced only if enabled and above current level; code still serves the pin interrupt at any level, level 3 included
// RULE24: highest software level first, then fixed order
// RULE25: core pushes context before loading the vector
package npic_pkg;
    localparam int NPIC_NVEC = 14;
    localparam logic [2:0] NPIC_OFF_PRIO0 = 3'h0;
    localparam logic [2:0] NPIC_OFF_PRIO1 = 3'h1;
    localparam logic [2:0] NPIC_OFF_PRIO2 = 3'h2;
    localparam logic [2:0] NPIC_OFF_PRIO3 = 3'h3;
    localparam logic [2:0] NPIC_OFF_CTRL = 3'h4;
    localparam logic [2:0] NPIC_OFF_STAT = 3'h5;
    localparam logic [7:0] NPIC_PRIO_RST = 8'hff;
    localparam logic [3:0] NPIC_PRIO3_HI = 4'hf;
    localparam logic [7:0] NPIC_CTRL_RST = 8'h01;
    localparam int NPIC_CTRL_NESTED_BIT = 0;
    localparam logic [1:0] NPIC_LVL0_CODE = 2'h2;
    localparam logic [1:0] NPIC_LVL1_CODE = 2'h1;
    localparam logic [1:0] NPIC_LVL2_CODE = 2'h0;
    localparam logic [1:0] NPIC_LVL3_CODE = 2'h3;
    localparam logic [15:0] NPIC_VEC_RESET = 16'hfffe;
    localparam logic [15:0] NPIC_VEC_TRAP = 16'hfffc;
    localparam logic [15:0] NPIC_VEC_TOP = 16'hfffa;
    localparam logic [15:0] NPIC_VEC_STEP = 16'h0002;
    localparam int NPIC_UNUSED_VEC = 6;
    localparam int NPIC_SPI_VEC = 7;
    localparam int NPIC_ART_VEC = 13;
    // fixed wake-from-halt capability, bits 7 and 13 are conditional
    localparam logic [13:0] NPIC_WAKE_FIXED = 14'h003f;
    localparam logic [13:0] NPIC_VALID_VEC = 14'h3fbf;
    localparam int NPIC_DEPTH_W = 4;
endpackage : npic_pkg

//--- npic_ctrl.sv
// Purpose: priority arbitration, level bits and wake decision
// Assumes: core pulses ack at an instruction end, one cycle strobes
// Notes: register port reads answer one cycle after the read strobe
`timescale 1ns/10ps
module npic_ctrl
    import npic_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [13:0] src_flag_in,
    input wire logic [13:0] src_enable_in,
    input wire logic [13:0] src_clear_in,
    input wire logic spi_slave_in,
    input wire logic art_ext_clk_in,
    input wire logic halted_in,
    input wire logic irq_ack_in,
    input wire logic irq_enable_instr_in,
    input wire logic irq_disable_instr_in,
    input wire logic halt_instr_in,
    input wire logic wait_for_irq_instr_in,
    input wire logic trap_instr_in,
    input wire logic irq_return_instr_in,
    input wire logic pop_flags_in,
    input wire logic [1:0] stacked_level_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic level_bit_high_out,
    output logic level_bit_low_out,
    output logic wake_halt_out,
    output logic wake_wait_out
);
    typedef struct packed {
        logic [31:0] prio;
        logic [7:0] ctrl;
        logic [1:0] cc;
        logic [13:0] pend;
        logic [NPIC_DEPTH_W-1:0] depth;
        logic halted_prev;
        logic halt_exit;
        logic req;
        logic [3:0] sel;
        logic [15:0] vec;
        logic [7:0] rdata;
        logic wake_halt;
        logic wake_wait;
    } npic_state_type;

    npic_state_type st_r;
    npic_state_type st_nxt;

    // *****************************************************
    // level decode
    // *****************************************************
    function automatic logic [1:0] npic_level(input logic [1:0] code);
        logic [1:0] l;
        unique case (code)
            NPIC_LVL0_CODE: l = 2'h0; // RULE8
            NPIC_LVL1_CODE: l = 2'h1;
            NPIC_LVL2_CODE: l = 2'h2;
            default: l = 2'h3;
        endcase
        return l;
    endfunction : npic_level

    // *****************************************************
    // request gathering and arbitration
    // *****************************************************
    logic [13:0] raw_req;
    logic [13:0] wake_cap;
    logic [13:0] elig;
    logic [1:0] cur_lvl;
    logic nest_block;
    logic restrict_halt;
    logic found;
    logic [3:0] win;
    logic [2:0] win_lvl;
    logic [2:0] l;

    assign raw_req = src_flag_in & src_enable_in & NPIC_VALID_VEC; // RULE1
    always_comb begin
        wake_cap = NPIC_WAKE_FIXED; // RULE20
        wake_cap[NPIC_SPI_VEC] = spi_slave_in; // RULE21
        wake_cap[NPIC_ART_VEC] = art_ext_clk_in; // RULE21
    end
    assign cur_lvl = npic_level(st_r.cc);
    // concurrent mode: a running handler is not preempted except by the pin interrupt
    assign nest_block = (st_r.depth != '0) && !st_r.ctrl[NPIC_CTRL_NESTED_BIT]; // RULE6
    // while halted or just after, only wake-capable sources compete
    assign restrict_halt = halted_in || st_r.halt_exit; // RULE4 RULE5

    always_comb begin
        elig = '0;
        // pin interrupt pair is ignored: ranks above the top software level, not masked by the current level
        elig[0] = st_r.pend[0] && (!restrict_halt || wake_cap[0]); // RULE15 RULE14
        for (int i = 1; i < NPIC_NVEC; i++) begin
            elig[i] = st_r.pend[i] && !nest_block
                && (npic_level(st_r.prio[2*i +: 2]) > cur_lvl) // RULE23
                && (!restrict_halt || wake_cap[i]);
        end
    end

    always_comb begin
        found = 1'b0;
        win = 4'h0;
        win_lvl = 3'h0;
        l = 3'h0;
        // descending scan with >= so the lower vector number wins a tie
        for (int i = NPIC_NVEC - 1; i >= 0; i--) begin
            l = (i == 0) ? 3'h4 : {1'b0, npic_level(st_r.prio[2*i +: 2])};
            if (elig[i] && (!found || l >= win_lvl)) begin // RULE24 RULE7
                found = 1'b1;
                win = i[3:0];
                win_lvl = l;
            end
        end
    end

    // *****************************************************
    // next state
    // *****************************************************
    always_comb begin
        logic [7:0] wbyte;
        logic [7:0] old;
        wbyte = reg_wdata_in;
        old = 8'h00;
        st_nxt = st_r;
        st_nxt.halted_prev = halted_in;

        // register writes
        if (reg_wr_in) begin
            if (reg_addr_in <= NPIC_OFF_PRIO3) begin
                old = st_r.prio[8*reg_addr_in +: 8];
                for (int p = 0; p < 4; p++) begin
                    if (wbyte[2*p +: 2] == NPIC_LVL0_CODE) begin
                        wbyte[2*p +: 2] = old[2*p +: 2]; // RULE13
                    end
                end
                st_nxt.prio[8*reg_addr_in +: 8] = wbyte; // RULE12 RULE16
                st_nxt.prio[31:28] = NPIC_PRIO3_HI; // RULE11
            end else if (reg_addr_in == NPIC_OFF_CTRL) begin
                st_nxt.ctrl = {7'h00, reg_wdata_in[NPIC_CTRL_NESTED_BIT]};
            end
        end

        // register reads, data valid in the next cycle only
        st_nxt.rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                NPIC_OFF_PRIO0, NPIC_OFF_PRIO1, NPIC_OFF_PRIO2, NPIC_OFF_PRIO3: begin
                    st_nxt.rdata = st_r.prio[8*reg_addr_in +: 8];
                end
                NPIC_OFF_CTRL: st_nxt.rdata = st_r.ctrl;
                NPIC_OFF_STAT: st_nxt.rdata = {st_r.depth, 1'b0, st_r.halt_exit, st_r.cc};
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // latch: set wins over clear, so a fresh flag survives
        st_nxt.pend = (st_r.pend & ~src_clear_in) | raw_req; // RULE2

        // halt exit window lasts until the first entry
        if (st_r.halted_prev && !halted_in) begin
            st_nxt.halt_exit = 1'b1;
        end

        // level bits
        if (irq_ack_in && st_r.req) begin
            // core has pushed context at instruction end
            st_nxt.cc = (st_r.sel == 4'h0) ? NPIC_LVL3_CODE // RULE14
                : st_r.prio[2*st_r.sel +: 2]; // RULE9 RULE25
            st_nxt.pend[st_r.sel] = raw_req[st_r.sel]; // RULE16
            st_nxt.halt_exit = 1'b0; // RULE5
            // no overflow detection, depth wraps silently
            st_nxt.depth = st_r.depth + 1'b1; // RULE22
        end else if (trap_instr_in) begin
            st_nxt.cc = NPIC_LVL3_CODE; // RULE10 RULE17
            st_nxt.depth = st_r.depth + 1'b1;
        end else if (irq_return_instr_in) begin
            st_nxt.cc = stacked_level_in; // RULE17 RULE18
            st_nxt.depth = st_r.depth - 1'b1;
        end else if (pop_flags_in) begin
            st_nxt.cc = stacked_level_in; // RULE17 RULE18
        end else if (irq_enable_instr_in || halt_instr_in || wait_for_irq_instr_in) begin
            st_nxt.cc = NPIC_LVL0_CODE; // RULE17
        end else if (irq_disable_instr_in) begin
            st_nxt.cc = NPIC_LVL3_CODE; // RULE17
        end

        // request to the core, still high in the acknowledge cycle and dropped at the next edge
        st_nxt.req = found && !(irq_ack_in && st_r.req) && !trap_instr_in;
        st_nxt.sel = win;
        st_nxt.vec = NPIC_VEC_TOP - 16'(NPIC_VEC_STEP * win); // RULE19
        st_nxt.wake_wait = |st_r.pend; // RULE3
        st_nxt.wake_halt = |(st_r.pend & wake_cap); // RULE20 RULE21
    end

    // *****************************************************
    // state register
    // *****************************************************
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r.prio <= {4{NPIC_PRIO_RST}}; // RULE11
            st_r.ctrl <= NPIC_CTRL_RST;
            st_r.cc <= NPIC_LVL3_CODE;
            st_r.pend <= '0;
            st_r.depth <= '0;
            st_r.halted_prev <= 1'b0;
            st_r.halt_exit <= 1'b0;
            st_r.req <= 1'b0;
            st_r.sel <= 4'h0;
            st_r.vec <= NPIC_VEC_TOP;
            st_r.rdata <= 8'h00;
            st_r.wake_halt <= 1'b0;
            st_r.wake_wait <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign irq_req_out = st_r.req;
    assign irq_vector_out = st_r.vec;
    assign level_bit_high_out = st_r.cc[1];
    assign level_bit_low_out = st_r.cc[0];
    assign wake_halt_out = st_r.wake_halt;
    assign wake_wait_out = st_r.wake_wait;

    // *****************************************************
    // assertions
    // *****************************************************
    property p_req_needs_flag;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!(src_flag_in[2] && src_enable_in[2]) && !st_r.pend[2])
            |=> !st_r.pend[2];
    endproperty
    a_req_needs_flag: assert property (p_req_needs_flag) // RULE1
        else $error("pending set without enabled flag");

    property p_clear_drops;
        @(posedge clk_in) disable iff (!rst_b_in)
        (src_clear_in[8] && !raw_req[8] && !(irq_ack_in && st_r.req)) |=> !st_r.pend[8];
    endproperty
    a_clear_drops: assert property (p_clear_drops) // RULE2
        else $error("clear sequence did not drop latch");

    property p_wait_wake;
        @(posedge clk_in) disable iff (!rst_b_in)
        (|st_r.pend) |=> wake_wait_out;
    endproperty
    a_wait_wake: assert property (p_wait_wake) // RULE3
        else $error("pending request did not wake from wait");

    property p_halt_restrict;
        @(posedge clk_in) disable iff (!rst_b_in)
        (halted_in && found) |=> (wake_cap[st_r.sel] || !st_r.req);
    endproperty
    a_halt_restrict: assert property (p_halt_restrict) // RULE4
        else $error("non-waking source chosen during halt");

    property p_entry_level;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_ack_in && st_r.req && st_r.sel != 4'h0)
            |=> ({level_bit_high_out, level_bit_low_out} == $past(st_r.prio[2*st_r.sel +: 2]));
    endproperty
    a_entry_level: assert property (p_entry_level) // RULE9
        else $error("entry did not load vector priority");

    property p_pin_level3;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_ack_in && st_r.req && st_r.sel == 4'h0) |=> (st_r.cc == NPIC_LVL3_CODE);
    endproperty
    a_pin_level3: assert property (p_pin_level3) // RULE14
        else $error("pin interrupt entry not at level 3");

    property p_prio3_top;
        @(posedge clk_in) disable iff (!rst_b_in)
        st_r.prio[31:28] == NPIC_PRIO3_HI;
    endproperty
    a_prio3_top: assert property (p_prio3_top) // RULE11
        else $error("read-only nibble lost its ones");

    property p_lvl0_write_kept;
        @(posedge clk_in) disable iff (!rst_b_in)
        (reg_wr_in && reg_addr_in == NPIC_OFF_PRIO1 && reg_wdata_in[1:0] == NPIC_LVL0_CODE)
            |=> (st_r.prio[9:8] == $past(st_r.prio[9:8]));
    endproperty
    a_lvl0_write_kept: assert property (p_lvl0_write_kept) // RULE13
        else $error("level-0 pattern was stored");

    property p_enable_instr;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_enable_instr_in && !(irq_ack_in && st_r.req) && !trap_instr_in
            && !irq_return_instr_in && !pop_flags_in) |=> (st_r.cc == NPIC_LVL0_CODE);
    endproperty
    a_enable_instr: assert property (p_enable_instr) // RULE17
        else $error("enable instruction did not load level 0");

    property p_concurrent;
        @(posedge clk_in) disable iff (!rst_b_in)
        nest_block |-> (elig[13:1] == 13'h0000);
    endproperty
    a_concurrent: assert property (p_concurrent) // RULE6
        else $error("preemption in concurrent mode");

    property p_trap_level3;
        @(posedge clk_in) disable iff (!rst_b_in)
        (trap_instr_in && !(irq_ack_in && st_r.req)) |=> (st_r.cc == NPIC_LVL3_CODE);
    endproperty
    a_trap_level3: assert property (p_trap_level3) // RULE10
        else $error("trap did not load level 3");

    property p_return_restore;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_return_instr_in && !(irq_ack_in && st_r.req) && !trap_instr_in)
            |=> (st_r.cc == $past(stacked_level_in));
    endproperty
    a_return_restore: assert property (p_return_restore) // RULE17
        else $error("return did not restore level");

    property p_pop_restore;
        @(posedge clk_in) disable iff (!rst_b_in)
        (pop_flags_in && !(irq_ack_in && st_r.req) && !trap_instr_in && !irq_return_instr_in)
            |=> (st_r.cc == $past(stacked_level_in));
    endproperty
    a_pop_restore: assert property (p_pop_restore) // RULE18
        else $error("pop did not restore level");

    property p_unused_vec;
        @(posedge clk_in) disable iff (!rst_b_in)
        irq_req_out |-> (st_r.sel != 4'(NPIC_UNUSED_VEC));
    endproperty
    a_unused_vec: assert property (p_unused_vec) // RULE19
        else $error("unused vector slot requested");

    property p_wake_halt;
        @(posedge clk_in) disable iff (!rst_b_in)
        (|(st_r.pend & wake_cap)) |=> wake_halt_out;
    endproperty
    a_wake_halt: assert property (p_wake_halt) // RULE20
        else $error("wake-capable request did not wake halt");

    property p_depth_entry;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_ack_in && st_r.req) |=> (st_r.depth == $past(st_r.depth) + 4'h1);
    endproperty
    a_depth_entry: assert property (p_depth_entry) // RULE22
        else $error("entry did not count nesting depth");

    property p_pin_wins;
        @(posedge clk_in) disable iff (!rst_b_in)
        (st_r.pend[0] && !restrict_halt) |-> (found && win == 4'h0);
    endproperty
    a_pin_wins: assert property (p_pin_wins) // RULE15
        else $error("pin interrupt lost arbitration");

    property p_ack_drops_req;
        @(posedge clk_in) disable iff (!rst_b_in)
        (irq_ack_in && st_r.req) |=> !irq_req_out;
    endproperty
    a_ack_drops_req: assert property (p_ack_drops_req) // RULE23
        else $error("request stood after entry");

    c_ack: cover property (@(posedge clk_in) disable iff (!rst_b_in) irq_req_out ##1 irq_ack_in);
    c_trap: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        trap_instr_in && st_r.cc == NPIC_LVL3_CODE);
    c_halt_exit: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        $fell(halted_in) ##[1:20] (irq_ack_in && st_r.req));
    c_nested: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        (st_r.depth == 4'h2));
endmodule : npic_ctrl

//--- npic_core_model.sv
// Purpose: core model that accepts interrupt entries
// Assumes: an entry is made only while the request stands
// Notes: delay_in picks prompt or slow acceptance
`timescale 1ns/10ps
module npic_core_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ack_en_in,
    input wire logic [3:0] delay_in,
    input wire logic irq_req_in,
    output logic irq_ack_out
);
    // ************
    // entry accept
    // ************
    logic [3:0] wait_r;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_r <= 4'h0;
            irq_ack_out <= 1'b0;
        end else if (irq_ack_out || !irq_req_in || !ack_en_in) begin
            // one-cycle pulse, rearmed for the next entry
            wait_r <= 4'h0;
            irq_ack_out <= 1'b0;
        end else if (wait_r == delay_in) begin
            irq_ack_out <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : npic_core_model

//--- test_nested_priority_interrupt_controller.sv
// Purpose: self-checking bench for the priority interrupt controller
// Assumes: core model takes entries, bench drives sources and registers
// Notes: inputs change by non-blocking assignment, on rising edges or 1 ns after them
`timescale 1ns/10ps
module test_nested_priority_interrupt_controller
    import npic_pkg::*;
;
    // *******
    // signals
    // *******
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ack_en = 1'b0;
    logic halted = 1'b0;
    logic spi_sl = 1'b0;
    logic art_ext = 1'b0;
    logic [13:0] flag = 14'h0000;
    logic [13:0] en = 14'h0000;
    logic [13:0] clr = 14'h0000;
    // enable, disable, halt, wait, trap, return, pop
    logic [6:0] ins = 7'h00;
    logic [1:0] stk = 2'h2;
    logic [3:0] dly = 4'h0;
    logic [7:0] rdata;
    logic [15:0] vec;
    logic req, ack, lh, ll, wh, ww;
    int error_cnt = 0;
    int total_checks = 0;
    always #5 clk_in = ~clk_in;
    npic_ctrl DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .src_flag_in(flag), .src_enable_in(en), .src_clear_in(clr),
        .spi_slave_in(spi_sl), .art_ext_clk_in(art_ext), .halted_in(halted),
        .irq_ack_in(ack), .irq_enable_instr_in(ins[0]), .irq_disable_instr_in(ins[1]),
        .halt_instr_in(ins[2]), .wait_for_irq_instr_in(ins[3]), .trap_instr_in(ins[4]),
        .irq_return_instr_in(ins[5]), .pop_flags_in(ins[6]), .stacked_level_in(stk),
        .irq_req_out(req), .irq_vector_out(vec), .level_bit_high_out(lh),
        .level_bit_low_out(ll), .wake_halt_out(wh), .wake_wait_out(ww));
    npic_core_model core (.clk_in(clk_in), .rst_b_in(rst_b_in), .ack_en_in(ack_en),
        .delay_in(dly), .irq_req_in(req), .irq_ack_out(ack));
    // *******
    // helpers
    // *******
    task automatic complete_run;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bail(input int n);
        if (n >= 30) begin
            chk("wait bound", 16'h0000, 16'h0001);
            complete_run();
        end
    endtask : bail
    task automatic lvl(input logic [1:0] e);
        chk("level", {14'h0, e}, {14'h0, lh, ll});
    endtask : lvl
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask : reg_rd
    task automatic instr(input int i, input logic [1:0] s);
        @(posedge clk_in);
        ins[i] <= 1'b1;
        stk <= s;
        @(posedge clk_in);
        ins[i] <= 1'b0;
        #1;
    endtask : instr
    task automatic raise(input logic [13:0] m);
        @(posedge clk_in);
        flag <= flag | m;
        en <= en | m;
    endtask : raise
    // clear pulse also drops the controller's pending copy
    task automatic drop(input logic [13:0] m);
        @(posedge clk_in);
        flag <= flag & ~m;
        clr <= m;
        @(posedge clk_in);
        clr <= 14'h0000;
    endtask : drop
    task automatic no_req(input int c);
        repeat (c) begin
            @(posedge clk_in);
            #1;
            chk("idle request", 16'h0000, {15'h0, req});
        end
    endtask : no_req
    task automatic wait_req(input int v);
        int n;
        for (n = 0; n < 30 && req !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        bail(n);
        chk("vector", NPIC_VEC_TOP - NPIC_VEC_STEP * 16'(v), vec);
    endtask : wait_req
    task automatic take(input logic [1:0] e);
        int n;
        @(posedge clk_in);
        ack_en <= 1'b1;
        for (n = 0; n < 30 && ack !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        bail(n);
        @(posedge clk_in);
        ack_en <= 1'b0;
        #1;
        lvl(e);
        @(posedge clk_in);
    endtask : take
    // *********
    // scenarios
    // *********
    task automatic t_regs;
        lvl(NPIC_LVL3_CODE);
        for (int i = 0; i < 4; i++) begin
            reg_rd(3'(i), NPIC_PRIO_RST);
        end
        reg_rd(3'h6, 8'h00);
        reg_wr(3'h0, 8'hcf);
        reg_wr(3'h0, 8'h64);
        reg_rd(3'h0, 8'h44);
        reg_wr(3'h3, 8'h00);
        reg_rd(3'h3, 8'hf0);
        reg_wr(3'h0, 8'h55);
        reg_rd(3'h0, 8'h55);
        reg_wr(3'h2, 8'hfc);
    endtask : t_regs
    task automatic t_mask;
        instr(0, 2'h2);
        lvl(NPIC_LVL0_CODE);
        @(posedge clk_in);
        flag[2] <= 1'b1;
        no_req(4);
        raise(14'h0004);
        wait_req(2);
        chk("wake wait", 16'h0001, {15'h0, ww});
        take(NPIC_LVL1_CODE);
        no_req(4);
        drop(14'h0004);
        instr(5, 2'h2);
        no_req(4);
    endtask : t_mask
    task automatic t_order;
        raise(14'h010c);
        wait_req(8);
        take(NPIC_LVL2_CODE);
        drop(14'h0100);
        instr(5, 2'h2);
        wait_req(2);
        dly <= 4'h3;
        take(NPIC_LVL1_CODE);
        drop(14'h0004);
        instr(5, 2'h2);
        wait_req(3);
        take(NPIC_LVL1_CODE);
        dly <= 4'h0;
        drop(14'h0008);
        instr(5, 2'h2);
    endtask : t_order
    task automatic t_halt;
        instr(2, 2'h2);
        lvl(NPIC_LVL0_CODE);
        halted <= 1'b1;
        raise(14'h0100);
        no_req(3);
        chk("wake halt", 16'h0000, {15'h0, wh});
        raise(14'h0004);
        wait_req(2);
        chk("wake halt", 16'h0001, {15'h0, wh});
        halted <= 1'b0;
        take(NPIC_LVL1_CODE);
        wait_req(8);
        take(NPIC_LVL2_CODE);
        drop(14'h0100);
        instr(5, 2'h1);
        no_req(3);
        drop(14'h0004);
        instr(5, 2'h2);
    endtask : t_halt
    task automatic t_wake;
        instr(2, 2'h2);
        halted <= 1'b1;
        raise(14'h0080);
        no_req(3);
        chk("wake halt", 16'h0000, {15'h0, wh});
        spi_sl <= 1'b1;
        wait_req(7);
        chk("wake halt", 16'h0001, {15'h0, wh});
        halted <= 1'b0;
        take(NPIC_LVL3_CODE);
        drop(14'h0080);
        spi_sl <= 1'b0;
        instr(5, 2'h2);
        halted <= 1'b1;
        raise(14'h2000);
        no_req(3);
        chk("wake halt", 16'h0000, {15'h0, wh});
        art_ext <= 1'b1;
        wait_req(13);
        chk("wake halt", 16'h0001, {15'h0, wh});
        halted <= 1'b0;
        take(NPIC_LVL2_CODE);
        drop(14'h2000);
        art_ext <= 1'b0;
        instr(5, 2'h2);
    endtask : t_wake
    task automatic t_conc;
        reg_wr(NPIC_OFF_CTRL, 8'h00);
        raise(14'h0004);
        wait_req(2);
        take(NPIC_LVL1_CODE);
        raise(14'h0100);
        no_req(4);
        drop(14'h0004);
        instr(5, 2'h2);
        wait_req(8);
        take(NPIC_LVL2_CODE);
        drop(14'h0100);
        instr(5, 2'h2);
        reg_wr(NPIC_OFF_CTRL, NPIC_CTRL_RST);
    endtask : t_conc
    task automatic t_trap;
        instr(1, 2'h2);
        instr(4, 2'h2);
        lvl(NPIC_LVL3_CODE);
        instr(3, 2'h2);
        lvl(NPIC_LVL0_CODE);
        instr(1, 2'h2);
        lvl(NPIC_LVL3_CODE);
        raise(14'h0001);
        wait_req(0);
        take(NPIC_LVL3_CODE);
        drop(14'h0001);
        instr(6, 2'h2);
        lvl(NPIC_LVL0_CODE);
    endtask : t_trap
    initial begin
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1;
        t_regs();
        t_mask();
        t_order();
        t_halt();
        t_wake();
        t_conc();
        t_trap();
        complete_run();
    end
endmodule : test_nested_priority_interrupt_controller
